// File: common/pcu_regs.vh
/*
 * Register offsets, field positions and reset values of the position
 * capture unit. Assumes inclusion by bare name from design files.
 */
`ifndef PCU_REGS_VH
`define PCU_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (16-bit parameter words)
// ----------------------------------------------------------------------
`define PCU_OFS_DONE_FLAGS     16'h0A02
`define PCU_OFS_EDGE_SELECT    16'h0A06
`define PCU_OFS_RUN_CONTROL    16'h0A0A
`define PCU_OFS_POS_HIGH       16'h0A0E
`define PCU_OFS_POS_LOW        16'h0A0F
`define PCU_OFS_EVENT_TALLY    16'h0A12

// ----------------------------------------------------------------------
// Field values and positions
// ----------------------------------------------------------------------
`define PCU_MODE_STOP          16'h0000
`define PCU_MODE_SINGLE        16'h0001
`define PCU_MODE_CONT          16'h0002
`define PCU_EDGE_FALL          1'b0
`define PCU_EDGE_RISE          1'b1
`define PCU_FLAG_A_BIT         0
`define PCU_FLAG_B_BIT         1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCU_RST_EDGE_SELECT    1'b0
`define PCU_RST_POSITION       32'h00000000
`define PCU_RST_TALLY          16'h0000
`define PCU_RST_WORD           16'h0000

`endif

// File: design/pcu_edge_detect.v
/*
 * Two-flop synchroniser and edge detector for one capture pin.
 * Assumes the pin is asynchronous to clock; pulses last one cycle.
 */
`timescale 1ns/1ps

module pcu_edge_detect (
    input  wire clock,
    input  wire sys_rst,
    input  wire pin_in,
    output reg  rise_pulse,
    output reg  fall_pulse
);

    reg meta_r;
    reg sync_r;
    reg last_r;

    // --------------------------------------------------------------
    // Synchroniser, then edge compare on the second and third flops
    // --------------------------------------------------------------
    always @(posedge clock) begin
        if (sys_rst) begin
            meta_r     <= 1'b0;
            sync_r     <= 1'b0;
            last_r     <= 1'b0;
            rise_pulse <= 1'b0;
            fall_pulse <= 1'b0;
        end else begin
            meta_r     <= pin_in;
            sync_r     <= meta_r;
            last_r     <= sync_r;
            rise_pulse <= sync_r & ~last_r;
            fall_pulse <= ~sync_r & last_r;
        end
    end

endmodule // pcu_edge_detect

// File: design/pcu_capture_unit.v
/*
 * Second position capture channel with its parameter word port and the
 * shared done-flag word. Assumes motor_position and the position-set
 * strobe come from logic on clock; capture pins are asynchronous.
 */
`timescale 1ns/1ps
`include "pcu_regs.vh"

module pcu_capture_unit (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        latch_input_b,
    input  wire [31:0] motor_position,
    input  wire        pos_set_strobe,
    input  wire [31:0] pos_set_delta,
    input  wire        unit_a_done_pulse,
    input  wire        unit_a_arm_pulse,
    input  wire [15:0] param_addr,
    input  wire [15:0] param_wdata,
    input  wire        param_wr,
    input  wire        param_rd,
    output reg  [15:0] param_rdata,
    output reg         param_rvalid,
    output reg         param_err,
    output reg         unit_b_busy
);

    // --------------------------------------------------------------
    // Run state codes
    // --------------------------------------------------------------
    localparam [2:0] ST_STOP   = 3'h1;
    localparam [2:0] ST_SINGLE = 3'h2;
    localparam [2:0] ST_CONT   = 3'h4;

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg         unit_b_edge_select_r;
    reg  [31:0] unit_b_latched_position_r;
    reg  [15:0] unit_b_event_tally_r;
    reg  [1:0]  latch_done_flags_r;
    reg  [15:0] rdata_nxt;
    reg         hit_nxt;

    wire        rise_b;
    wire        fall_b;
    wire        edge_b;
    wire        capture_b;
    wire        wr_run;
    wire        wr_edge;
    wire        arm_b;

    // --------------------------------------------------------------
    // Pin synchronisation and edge qualification
    // --------------------------------------------------------------
    pcu_edge_detect u_edge_b (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .pin_in     (latch_input_b),
        .rise_pulse (rise_b),
        .fall_pulse (fall_b)
    );

    assign edge_b    = (unit_b_edge_select_r == `PCU_EDGE_RISE) ? rise_b : fall_b;
    assign capture_b = edge_b & (state_r != ST_STOP);
    assign wr_run    = param_wr & (param_addr == `PCU_OFS_RUN_CONTROL);
    assign wr_edge   = param_wr & (param_addr == `PCU_OFS_EDGE_SELECT);
    assign arm_b     = wr_run & ((param_wdata == `PCU_MODE_SINGLE) | (param_wdata == `PCU_MODE_CONT));

    // --------------------------------------------------------------
    // Run state machine; a write in the capture cycle takes priority
    // --------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_STOP: begin
                state_nxt = ST_STOP;
            end
            ST_SINGLE: begin
                if (capture_b) begin
                    state_nxt = ST_STOP;
                end
            end
            ST_CONT: begin
                state_nxt = ST_CONT;
            end
            default: begin
                state_nxt = ST_STOP;
            end
        endcase
        if (wr_run) begin
            if (param_wdata == `PCU_MODE_STOP) begin
                state_nxt = ST_STOP;
            end else if (param_wdata == `PCU_MODE_SINGLE) begin
                state_nxt = ST_SINGLE;
            end else if (param_wdata == `PCU_MODE_CONT) begin
                state_nxt = ST_CONT;
            end
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            state_r     <= ST_STOP;
            unit_b_busy <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            unit_b_busy <= (state_nxt != ST_STOP);
        end
    end

    // --------------------------------------------------------------
    // Configuration, captured position, tally and done flags
    // --------------------------------------------------------------
    always @(posedge clock) begin
        if (sys_rst) begin
            unit_b_edge_select_r      <= `PCU_RST_EDGE_SELECT;
            unit_b_latched_position_r <= `PCU_RST_POSITION;
            unit_b_event_tally_r      <= `PCU_RST_TALLY;
            latch_done_flags_r        <= 2'h0;
        end else begin
            if (wr_edge) begin
                unit_b_edge_select_r <= param_wdata[0];
            end
            if (capture_b) begin
                unit_b_latched_position_r <= motor_position;
            end else if (pos_set_strobe) begin
                unit_b_latched_position_r <= unit_b_latched_position_r + pos_set_delta;
            end
            if (arm_b) begin
                unit_b_event_tally_r <= `PCU_RST_TALLY;
            end else if (capture_b) begin
                unit_b_event_tally_r <= unit_b_event_tally_r + 16'h0001;
            end
            if (unit_a_done_pulse) begin
                latch_done_flags_r[`PCU_FLAG_A_BIT] <= 1'b1;
            end else if (unit_a_arm_pulse) begin
                latch_done_flags_r[`PCU_FLAG_A_BIT] <= 1'b0;
            end
            // A capture in the cycle of a re-arm still marks the flag: set wins
            if (capture_b) begin
                latch_done_flags_r[`PCU_FLAG_B_BIT] <= 1'b1;
            end else if (arm_b) begin
                latch_done_flags_r[`PCU_FLAG_B_BIT] <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Parameter word read decode
    // --------------------------------------------------------------
    always @* begin
        rdata_nxt = `PCU_RST_WORD;
        hit_nxt   = 1'b1;
        case (param_addr)
            `PCU_OFS_DONE_FLAGS:  rdata_nxt = {14'h0000, latch_done_flags_r};
            `PCU_OFS_EDGE_SELECT: rdata_nxt = {15'h0000, unit_b_edge_select_r};
            `PCU_OFS_RUN_CONTROL: rdata_nxt = (state_r == ST_SINGLE) ? `PCU_MODE_SINGLE :
                                              (state_r == ST_CONT)   ? `PCU_MODE_CONT : `PCU_MODE_STOP;
            `PCU_OFS_POS_HIGH:    rdata_nxt = unit_b_latched_position_r[31:16];
            `PCU_OFS_POS_LOW:     rdata_nxt = unit_b_latched_position_r[15:0];
            `PCU_OFS_EVENT_TALLY: rdata_nxt = unit_b_event_tally_r;
            default:              hit_nxt   = 1'b0;
        endcase
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            param_rdata  <= `PCU_RST_WORD;
            param_rvalid <= 1'b0;
            param_err    <= 1'b0;
        end else begin
            param_rvalid <= param_rd | param_wr;
            param_rdata  <= param_rd ? rdata_nxt : `PCU_RST_WORD;
            param_err    <= (param_rd & ~hit_nxt) |
                            (param_wr & ~wr_edge & ~(wr_run & (param_wdata[15:2] == 14'h0000) &
                                                   (param_wdata[1:0] != 2'h3)));
        end
    end

endmodule // pcu_capture_unit

// File: verif/pcu_capture_props.sv
/* Port checker for pcu_capture_unit.
   Assumes a bind from the bench top. */
`timescale 1ns/1ps
module pcu_capture_props (
    input wire        clock,
    input wire        sys_rst,
    input wire        latch_input_b,
    input wire [31:0] motor_position,
    input wire        pos_set_strobe,
    input wire [31:0] pos_set_delta,
    input wire        unit_a_done_pulse,
    input wire        unit_a_arm_pulse,
    input wire [15:0] param_addr,
    input wire [15:0] param_wdata,
    input wire        param_wr,
    input wire        param_rd,
    input wire [15:0] param_rdata,
    input wire        param_rvalid,
    input wire        param_err,
    input wire        unit_b_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire mw = param_wr && param_addr == 16'h0A0A;
    wire ro = param_wr && (param_addr == 16'h0A02 || param_addr == 16'h0A0E ||
              param_addr == 16'h0A0F || param_addr == 16'h0A12);
    chk_req_answer: assert property ((param_wr || param_rd) |=> param_rvalid)
        else $error("request got no answer");
    chk_mode_arm: assert property (mw && param_wdata inside {16'h0001, 16'h0002} |=> unit_b_busy && !param_err)
        else $error("arm write did not arm");
    chk_mode_bad: assert property (mw && param_wdata > 16'h0002 |=> param_err)
        else $error("bad mode accepted");
    chk_mode_cancel: assert property (mw && param_wdata == 16'h0000 |=> !unit_b_busy)
        else $error("cancel left unit busy");
    chk_ro_write: assert property (ro |=> param_err)
        else $error("read-only write accepted");
    chk_busy_cause: assert property ($rose(unit_b_busy) |-> $past(mw))
        else $error("busy rose without arm");
    chk_flag_bits: assert property (param_rd && param_addr == 16'h0A02 |=> param_rdata[15:2] == 14'h0)
        else $error("stray done flag bits");
    chk_edge_bits: assert property (param_rd && param_addr == 16'h0A06 |=> param_rdata[15:1] == 15'h0)
        else $error("stray edge select bits");
    chk_mode_range: assert property (param_rd && param_addr == 16'h0A0A |=> param_rdata <= 16'h0002)
        else $error("run mode out of range");
endmodule // pcu_capture_props

// File: verif/pcu_pin_src.sv
/* Behavioural source of capture pin b.
   Assumes want changes just after a clock edge. */
`timescale 1ns/1ps
module pcu_pin_src (
    input  wire clock,
    input  wire want,
    input  wire slow,
    output reg  pin
);
    integer wait_r = 0;
    initial pin = 1'h0;
    // Slow mode delays each level change by six cycles
    always @(posedge clock) begin
        if (want == pin)
            wait_r <= 0;
        else if (!slow || wait_r == 5)
            pin <= want;
        else
            wait_r <= wait_r + 1;
    end
endmodule // pcu_pin_src

// File: verif/tb.sv
/* Self-checking bench of pcu_capture_unit against a behavioural model.
   Assumes pcu_pin_src drives the capture pin. */
`timescale 1ns/1ps
module tb;
    reg         clock = 1'h0, sys_rst = 1'h1, latch_req = 1'h0, slow = 1'h0;
    reg         pos_set_strobe = 1'h0, unit_a_done_pulse = 1'h0, unit_a_arm_pulse = 1'h0;
    reg         param_wr = 1'h0, param_rd = 1'h0, esel = 1'h0;
    reg  [31:0] motor_position = 32'h0, pos_set_delta = 32'h0, pos = 32'h0;
    reg  [15:0] param_addr = 16'h0, param_wdata = 16'h0, flags = 16'h0;
    wire [15:0] param_rdata;
    wire        param_rvalid, param_err, unit_b_busy, latch_input_b;
    integer     fail_count = 0, num_checks = 0, tally = 0, mode = 0, i;
    pcu_capture_unit pcu_capture_unit_i (
        .clock             (clock),
        .sys_rst           (sys_rst),
        .latch_input_b     (latch_input_b),
        .motor_position    (motor_position),
        .pos_set_strobe    (pos_set_strobe),
        .pos_set_delta     (pos_set_delta),
        .unit_a_done_pulse (unit_a_done_pulse),
        .unit_a_arm_pulse  (unit_a_arm_pulse),
        .param_addr        (param_addr),
        .param_wdata       (param_wdata),
        .param_wr          (param_wr),
        .param_rd          (param_rd),
        .param_rdata       (param_rdata),
        .param_rvalid      (param_rvalid),
        .param_err         (param_err),
        .unit_b_busy       (unit_b_busy)
    );
    pcu_pin_src pcu_pin_src_i (.clock(clock), .want(latch_req), .slow(slow), .pin(latch_input_b));
    initial forever #10 clock = ~clock;
    task final_report;
        begin
            if (fail_count == 0 && num_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task ck(input [31:0] g, input [31:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task acc(input w, input [15:0] a, input [15:0] d, input [15:0] e, input ee);
        begin
            @(posedge clock) #1;
            param_wr = w;
            param_rd = !w;
            param_addr = a;
            param_wdata = d;
            @(posedge clock) #1;
            param_wr = 1'h0;
            param_rd = 1'h0;
            ck(param_rvalid, 1);
            ck(param_err, ee);
            if (!w)
                ck(param_rdata, e);
        end
    endtask
    task chkall;
        begin
            acc(0, 16'h0A12, 0, tally[15:0], 0);
            acc(0, 16'h0A0E, 0, pos[31:16], 0);
            acc(0, 16'h0A0F, 0, pos[15:0], 0);
            acc(0, 16'h0A02, 0, flags, 0);
            acc(0, 16'h0A0A, 0, mode[15:0], 0);
            acc(0, 16'h0A06, 0, {15'h0, esel}, 0);
        end
    endtask
    task arm(input [15:0] m);
        begin
            acc(1, 16'h0A0A, m, 0, 0);
            mode = m;
            if (m != 0) begin
                tally = 0;
                flags[1] = 1'h0;
            end
            ck(unit_b_busy, m != 0);
        end
    endtask
    task pin(input v);
        begin
            @(posedge clock) #1;
            motor_position = $urandom;
            if (v != latch_req && v == esel && mode != 0) begin
                pos = motor_position;
                tally = tally + 1;
                flags[1] = 1'h1;
                if (mode == 1)
                    mode = 0;
            end
            latch_req = v;
            repeat (14) @(posedge clock);
            #1;
            ck(unit_b_busy, mode != 0);
        end
    endtask
    initial begin
        #100000;
        fail_count = fail_count + 1;
        final_report;
    end
    initial begin
        i = $urandom(32'h10FC9265);
        repeat (5) @(posedge clock);
        #1 sys_rst = 1'h0;
        chkall;
        acc(1, 16'h0A06, 16'h0001, 0, 0);
        esel = 1'h1;
        arm(1);
        pin(1);
        pin(0);
        pin(1);
        chkall;
        acc(1, 16'h0A06, 16'h0000, 0, 0);
        esel = 1'h0;
        slow = 1'h1;
        arm(2);
        for (i = 0; i < 4; i = i + 1)
            pin(i[0]);
        chkall;
        @(posedge clock) #1;
        pos_set_delta = $urandom;
        pos_set_strobe = 1'h1;
        @(posedge clock) #1;
        pos_set_strobe = 1'h0;
        pos = pos + pos_set_delta;
        chkall;
        arm(0);
        pin(1);
        pin(0);
        unit_a_done_pulse = 1'h1;
        @(posedge clock) #1;
        unit_a_done_pulse = 1'h0;
        flags[0] = 1'h1;
        chkall;
        unit_a_arm_pulse = 1'h1;
        @(posedge clock) #1;
        unit_a_arm_pulse = 1'h0;
        flags[0] = 1'h0;
        acc(1, 16'h0A0A, 16'h0003, 0, 1);
        acc(1, 16'h0A12, 16'h0005, 0, 1);
        acc(0, 16'h0B00, 0, 0, 1);
        arm(1);
        chkall;
        final_report;
    end
endmodule // tb
bind pcu_capture_unit pcu_capture_props pcu_capture_props_i (
    .clock             (clock),
    .sys_rst           (sys_rst),
    .latch_input_b     (latch_input_b),
    .motor_position    (motor_position),
    .pos_set_strobe    (pos_set_strobe),
    .pos_set_delta     (pos_set_delta),
    .unit_a_done_pulse (unit_a_done_pulse),
    .unit_a_arm_pulse  (unit_a_arm_pulse),
    .param_addr        (param_addr),
    .param_wdata       (param_wdata),
    .param_wr          (param_wr),
    .param_rd          (param_rd),
    .param_rdata       (param_rdata),
    .param_rvalid      (param_rvalid),
    .param_err         (param_err),
    .unit_b_busy       (unit_b_busy)
);
